//--- logic/plt_link_timing.v
/*
  Fast link pulse burst generator, link-loss indicator and interrupt, and
  strap capture at reset release, for a 10/100 transceiver.
  Assumes one 200 MHz clock; pins other than int_clear_in, ind_mode_in and the code word are synchronised here; the external
  reset controller keeps its own duties on reset length and management wait.
*/
`include "plt_timing_regs.vh"

module plt_link_timing #(
  parameter [31:0] BURST_GAP_CYC = `PLT_BURST_GAP_CYC,
  parameter [31:0] CLK_TO_CLK_CYC = `PLT_CLK_TO_CLK_CYC,
  parameter [31:0] CLK_TO_DATA_CYC = `PLT_CLK_TO_DATA_CYC
) (
  // clock and reset
  input wire ref_clk_in,
  input wire sys_rst_in,
  // negotiation control
  input wire an_enable_in,
  input wire an_done_in,
  input wire [15:0] an_code_word_in,
  // link status
  input wire speed_100_in,
  input wire [1:0] ind_mode_in,
  input wire signal_detect_in,
  input wire int_clear_in,
  // straps
  input wire [7:0] strap_in,
  // outputs
  output reg flp_pulse_out,
  output reg flp_burst_active_out,
  output reg link_indicator_output_out,
  output reg interrupt_request_pin_out,
  output reg [7:0] strap_cfg_out
);

  localparam ST_IDLE = 3'b001;
  localparam ST_BURST = 3'b010;
  localparam ST_GAP = 3'b100;
  localparam [31:0] PW_LAST = `PLT_PULSE_W_CYC - 1;
  localparam [31:0] LOSS_LAST = `PLT_LOSS_REACT_CYC - 1;

  wire [3:0] sync_q;
  wire an_en_s = sync_q[0];
  wire an_done_s = sync_q[1];
  wire sig_s = sync_q[2];
  wire spd_s = sync_q[3];
  wire [7:0] strap_s;

  // pins pass two flops before use
  plt_sync2 #(.W(4)) u_sync_ctl (
    .clk_in(ref_clk_in),
    .rst_in(sys_rst_in),
    .d_in({speed_100_in, signal_detect_in, an_done_in, an_enable_in}),
    .q_out(sync_q)
  );

  // strap sync keeps running through reset so the pin level is ready at release;
  // a reset here would hand over zeros at the capture edge
  plt_sync2 #(.W(8)) u_sync_strap (
    .clk_in(ref_clk_in),
    .rst_in(1'b0),
    .d_in(strap_in),
    .q_out(strap_s)
  );

  reg [2:0] state;
  reg [2:0] next_state;
  reg [22:0] gap_cnt;
  reg [15:0] slot_cnt;
  reg [4:0] slot_idx;
  reg [4:0] pw_cnt;
  reg [15:0] code_word;
  wire neg_run = an_en_s & ~an_done_s;
  wire slot_end = (slot_cnt == CLK_TO_CLK_CYC[15:0] - 16'h0001);
  wire last_slot = (slot_idx == `PLT_SLOTS_PER_BURST - 1);

  // burst sequencer: bursts repeat while negotiating
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (neg_run) next_state = ST_BURST;
      end
      ST_BURST: begin
        if (slot_end && last_slot) next_state = ST_GAP;
      end
      ST_GAP: begin
        if (!neg_run) next_state = ST_IDLE;
        else if (gap_cnt == BURST_GAP_CYC[22:0] - 23'h0000_01) next_state = ST_BURST;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // gap counter runs from burst start so bursts start a fixed gap apart
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      gap_cnt <= 23'h0000_00;
      slot_cnt <= 16'h0000;
      slot_idx <= 5'h00;
      code_word <= 16'h0000;
    end else begin
      state <= next_state;
      if (state == ST_IDLE || next_state == ST_BURST && state != ST_BURST) begin
        gap_cnt <= 23'h0000_00;
      end else begin
        gap_cnt <= gap_cnt + 23'h0000_01;
      end
      if (state == ST_BURST) begin
        if (slot_end) begin
          slot_cnt <= 16'h0000;
          slot_idx <= last_slot ? 5'h00 : slot_idx + 5'h01;
        end else begin
          slot_cnt <= slot_cnt + 16'h0001;
        end
      end else begin
        slot_cnt <= 16'h0000;
        slot_idx <= 5'h00;
        code_word <= an_code_word_in; // word frozen for the whole burst
      end
    end
  end

  // pulse start: clock at slot start, data bit at mid-slot; 17 clocks + up to 16 data
  wire data_bit = (slot_idx < 5'h10) ? code_word[slot_idx[3:0]] : 1'b0;
  wire clk_fire = (state == ST_BURST) && (slot_cnt == 16'h0000);
  wire data_fire = (state == ST_BURST) && data_bit
    && (slot_cnt == CLK_TO_DATA_CYC[15:0]);

  // pulse width shaper, 100 ns per pulse
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pw_cnt <= 5'h00;
      flp_pulse_out <= 1'b0;
      flp_burst_active_out <= 1'b0;
    end else begin
      flp_burst_active_out <= (state == ST_BURST);
      if (clk_fire || data_fire) begin
        pw_cnt <= PW_LAST[4:0];
        flp_pulse_out <= 1'b1;
      end else if (pw_cnt != 5'h00) begin
        pw_cnt <= pw_cnt - 5'h01;
      end else begin
        flp_pulse_out <= 1'b0;
      end
    end
  end

  // link-loss reaction timer; only 100 Mbps mode is timed here
  reg [9:0] loss_cnt;
  reg loss_seen;
  reg link_up;
  wire loss_fire = loss_seen && !sig_s && (loss_cnt == LOSS_LAST[9:0]);
  // link state kept apart from the indicator so the interrupt works in every indicator mode
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      loss_cnt <= 10'h000;
      loss_seen <= 1'b0;
      link_up <= 1'b0;
      link_indicator_output_out <= 1'b1;
      interrupt_request_pin_out <= 1'b0;
    end else begin
      if (sig_s) begin
        loss_cnt <= 10'h000;
        loss_seen <= 1'b0;
        if (spd_s) link_up <= 1'b1;
        if (spd_s && ind_mode_in == `PLT_IND_MODE_LINK) link_indicator_output_out <= 1'b0;
      end else if (spd_s && link_up && !loss_seen) begin
        loss_seen <= 1'b1;
      end else if (loss_seen && !loss_fire) begin
        loss_cnt <= loss_cnt + 10'h001;
      end
      if (loss_fire) begin
        loss_seen <= 1'b0;
        link_up <= 1'b0;
        if (ind_mode_in == `PLT_IND_MODE_LINK) link_indicator_output_out <= 1'b1;
      end
      // set wins over clear
      if (loss_fire) interrupt_request_pin_out <= 1'b1;
      else if (int_clear_in) interrupt_request_pin_out <= 1'b0;
    end
  end

  // straps caught on the first clock after reset release
  reg strap_done;
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_done <= 1'b0;
      strap_cfg_out <= `PLT_STRAP_RST;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap_cfg_out <= strap_s;
    end
  end

endmodule

//--- pkg/plt_timing_regs.vh
/*
  Timing constants for the link pulse and link-loss timing block.
  Assumes a 200 MHz clock (5 ns period); counts are derived from times.
*/
`ifndef PLT_TIMING_REGS_VH
`define PLT_TIMING_REGS_VH

`define PLT_CLK_PERIOD_NS 5
// burst spacing (ms) and burst length (ms)
`define PLT_BURST_GAP_MS 16
`define PLT_BURST_GAP_CYC (`PLT_BURST_GAP_MS * 1000000 / `PLT_CLK_PERIOD_NS)
`define PLT_BURST_LEN_MS 2
// clock-to-data and clock-to-clock spacing (ns)
`define PLT_CLK_TO_DATA_NS 64000
`define PLT_CLK_TO_DATA_CYC (`PLT_CLK_TO_DATA_NS / `PLT_CLK_PERIOD_NS)
`define PLT_CLK_TO_CLK_NS 128000
`define PLT_CLK_TO_CLK_CYC (`PLT_CLK_TO_CLK_NS / `PLT_CLK_PERIOD_NS)
// pulse width (ns)
`define PLT_PULSE_W_NS 100
`define PLT_PULSE_W_CYC (`PLT_PULSE_W_NS / `PLT_CLK_PERIOD_NS)
// link-loss reaction (ns)
`define PLT_LOSS_REACT_NS 4800
`define PLT_LOSS_REACT_CYC (`PLT_LOSS_REACT_NS / `PLT_CLK_PERIOD_NS)
// clock pulses per burst (17 total pulses minimum means 17 clock slots)
`define PLT_SLOTS_PER_BURST 17
// indicator mode that enables the link-down indicator
`define PLT_IND_MODE_LINK 2'b01
// strap word width
`define PLT_STRAP_W 8
`define PLT_STRAP_RST 8'h00

`endif

//--- logic/plt_sync2.v
/*
  Two-flop synchroniser for a vector of asynchronous inputs.
  Assumes the destination clock is the only clock; first stage read only by second.
*/
module plt_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // data
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);

  reg [W-1:0] meta;

  // first stage feeds only the second
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule

//--- sim/plt_link_monitor.sv
/* checker for burst, pulse and link-loss timing at the block ports.
   assumes bind to the top module and a single clock domain. */
module plt_link_monitor #(
  parameter int BURST_GAP_CYC = 2000,
  parameter int CLK_TO_CLK_CYC = 100,
  parameter int CLK_TO_DATA_CYC = 50
) (
  // clock, reset, inputs
  input logic ref_clk_in,
  input logic sys_rst_in,
  input logic signal_detect_in,
  input logic int_clear_in,
  input logic [15:0] an_code_word_in,
  // outputs watched
  input logic flp_pulse_out,
  input logic flp_burst_active_out,
  input logic link_indicator_output_out,
  input logic interrupt_request_pin_out,
  input logic [7:0] strap_cfg_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  int pw, off, gc, pc, lc, ec;
  // cycle counters; int wide so the long burst gap never wraps
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pw <= 0;
      off <= 0;
      gc <= 0;
      pc <= 0;
      lc <= 0;
      ec <= 0;
    end else begin
      pw <= flp_pulse_out ? pw + 1 : 0;
      off <= flp_burst_active_out ? off + 1 : 0;
      gc <= $rose(flp_burst_active_out) ? 1 : (gc != 0 ? gc + 1 : 0);
      pc <= flp_burst_active_out ? pc + $rose(flp_pulse_out) : 0;
      lc <= signal_detect_in ? 0 : lc + 1;
      ec <= ec < 3 ? ec + 1 : ec;
    end
  end
  a_pulse_width: assert property ($fell(flp_pulse_out) |-> pw == 20)
    else $error("pulse width wrong");
  a_pulse_inside: assert property (flp_pulse_out |-> flp_burst_active_out)
    else $error("pulse outside burst");
  a_pulse_slot: assert property ($rose(flp_pulse_out) |-> off % CLK_TO_CLK_CYC == 0
    || off % CLK_TO_CLK_CYC == CLK_TO_DATA_CYC) else $error("pulse off its slot");
  a_burst_gap: assert property ($rose(flp_burst_active_out) && gc != 0
    |-> gc == BURST_GAP_CYC) else $error("burst spacing wrong");
  a_burst_length: assert property ($fell(flp_burst_active_out)
    |-> off == 17 * CLK_TO_CLK_CYC) else $error("burst length wrong");
  a_pulse_count: assert property ($fell(flp_burst_active_out)
    |-> pc == 17 + $countones(an_code_word_in)) else $error("pulse count wrong");
  a_loss_irq: assert property ($rose(interrupt_request_pin_out) |-> lc > 957 && lc < 971)
    else $error("irq reaction time wrong");
  a_loss_led: assert property ($rose(link_indicator_output_out) |-> lc > 957 && lc < 971)
    else $error("indicator reaction time wrong");
  a_irq_sticky: assert property (interrupt_request_pin_out && !int_clear_in
    |=> interrupt_request_pin_out) else $error("irq dropped uncleared");
  a_strap_hold: assert property (ec >= 2 |-> $stable(strap_cfg_out))
    else $error("strap config changed");
endmodule

//--- sim/plt_far_end.sv
/* far-end model: host reset controller and link partner signal.
   assumes the bench clock; commands from the bench at the falling edge. */
module plt_far_end (
  // clock and command
  input logic clk_in,
  input logic drop_in,
  // to the block
  output logic rst_out,
  output logic sig_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // reset hold scaled down to 12 cycles; partner present once released
  // receive signal is driven from the first falling edge, well inside reset
  initial begin
    rst_out = 1'b1;
    repeat (12) @(negedge clk_in);
    rst_out = 1'b0;
  end
  // received signal follows the drop command one cycle late
  always @(negedge clk_in) sig_out <= !drop_in;
endmodule

//--- sim/tb_top.sv
/* bench for the link timing block: straps, link loss, pulse bursts.
   assumes the far-end model supplies reset and receive signal. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 2000, CTC = 100, CTD = 50;
  logic clk = 0, rst, sig, drop = 0, en = 0, done = 0, spd = 1, clr = 0;
  logic [1:0] mode = 2'h1;
  logic [15:0] code = 16'h0000;
  logic [7:0] strap = 8'ha5;
  wire pulse, burst, ind, irq;
  wire [7:0] cfg;
  wire [3:0] outs = {irq, ind, burst, pulse}; // indexed by the bounded wait
  int fails = 0, compares = 0;
  initial forever #2.5 clk = ~clk;
  plt_far_end i_far (.clk_in(clk), .drop_in(drop), .rst_out(rst), .sig_out(sig));
  plt_link_timing #(.BURST_GAP_CYC(GAP), .CLK_TO_CLK_CYC(CTC), .CLK_TO_DATA_CYC(CTD)) i_dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .an_enable_in(en), .an_done_in(done),
    .an_code_word_in(code), .speed_100_in(spd), .ind_mode_in(mode),
    .signal_detect_in(sig), .int_clear_in(clr), .strap_in(strap),
    .flp_pulse_out(pulse), .flp_burst_active_out(burst),
    .link_indicator_output_out(ind), .interrupt_request_pin_out(irq), .strap_cfg_out(cfg));
  task conclude;
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // bounded wait on one output; a hang counts as a mismatch
  task automatic wait_on(input int i, input logic lvl, output int n);
    n = 0;
    while (outs[i] !== lvl) begin
      if (n == 9000) begin
        fails++;
        conclude;
      end
      @(negedge clk);
      n++;
    end
  endtask
  task s_straps;
    check(cfg, 8'ha5);
    strap = 8'h3c;
    repeat (4) @(negedge clk);
    check(cfg, 8'ha5);
  endtask
  task s_loss;
    int n;
    check(ind, 1'b0);
    drop <= 1'b1;
    wait_on(3, 1'b1, n);
    check(n > 957 && n < 971, 1'b1);
    check(ind, 1'b1);
    repeat (50) @(negedge clk);
    check(irq, 1'b1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    check(irq, 1'b0);
    // indicator mode 00: link returns and drops again, indicator must hold
    mode = 2'h0;
    drop <= 1'b0;
    repeat (10) @(negedge clk);
    check(ind, 1'b1);
    drop <= 1'b1;
    wait_on(3, 1'b1, n);
    check(n > 957 && n < 971, 1'b1);
    check(ind, 1'b1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    mode = 2'h1;
    @(negedge clk);
    check(irq, 1'b0);
  endtask
  task s_burst(input logic [15:0] w);
    int n, c, p;
    logic q;
    wait_on(1, 1'b0, n);
    repeat (2) @(negedge clk);
    code = w;
    en = 1'b1;
    wait_on(1, 1'b1, n);
    c = 0;
    p = 0;
    q = 0;
    while (burst === 1'b1 && c < 3000) begin
      if (pulse === 1'b1 && q === 1'b0) p++;
      q = pulse;
      @(negedge clk);
      c++;
    end
    check(p, 17 + $countones(w));
    check(c, 17 * CTC);
    wait_on(1, 1'b1, n);
    check(c + n, GAP);
  endtask
  task s_done;
    int n, c;
    done = 1'b1;
    wait_on(1, 1'b0, n);
    c = 0;
    repeat (2 * GAP) begin
      if (burst !== 1'b0) c++;
      @(negedge clk);
    end
    check(c, 0);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    s_straps;
    s_loss;
    s_burst(16'h0000);
    s_burst(16'hffff);
    s_done;
    conclude;
  end
endmodule
bind plt_link_timing plt_link_monitor #(.BURST_GAP_CYC(BURST_GAP_CYC),
  .CLK_TO_CLK_CYC(CLK_TO_CLK_CYC), .CLK_TO_DATA_CYC(CLK_TO_DATA_CYC)) i_mon (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .signal_detect_in(signal_detect_in),
  .int_clear_in(int_clear_in), .an_code_word_in(an_code_word_in),
  .flp_pulse_out(flp_pulse_out), .flp_burst_active_out(flp_burst_active_out),
  .link_indicator_output_out(link_indicator_output_out),
  .interrupt_request_pin_out(interrupt_request_pin_out), .strap_cfg_out(strap_cfg_out));
